// ### dv/carp_bench.sv
// Purpose: self-checking bench of carp_top
// Assumes: config levels driven here in place of adc_config
// Notes:   irqs sampled one cycle after the result edge
`timescale 1ns/100ps
`default_nettype none
module carp_bench;
  import carp_pkg::*;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  carp_bus_req_t bus_req;
  logic          bus_ack, bus_hit, count_irq, cmp_irq, twos_comp, acc_subtract, reconfig_wr;
  logic [31:0]   bus_rdata;
  logic [7:0]    adc_config;
  carp_result_t  result_in;
  int            tests_run = 0;
  int            miscompares = 0;
  always #2 clk = ~clk;
  carp_top uut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_ack(bus_ack),
    .bus_hit(bus_hit), .bus_rdata(bus_rdata), .adc_config(adc_config), .twos_comp(twos_comp),
    .acc_subtract(acc_subtract), .reconfig_wr(reconfig_wr), .result_in(result_in),
    .count_irq(count_irq), .cmp_irq(cmp_irq));
  carp_core core (.clk(clk), .bus_req(bus_req), .bus_ack(bus_ack), .bus_hit(bus_hit),
    .bus_rdata(bus_rdata));
  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [31:0] a, d, e);
    logic [31:0] q;
    logic        h;
    logic        ok;
    core.access(w, a, d, q, h, ok);
    if (!ok) begin
      miscompares++;
      complete_run();
    end else begin
      check({31'h0, h}, {31'h0, (a inside {CARP_ADDR_COUNT_LIMIT, CARP_ADDR_COUNT_VALUE,
                                           CARP_ADDR_THRESHOLD, CARP_ADDR_ACCUM})});
      if (!w) check(q, e);
    end
  endtask : bus
  task automatic res(input logic [15:0] d, input logic ci, mi);
    @(posedge clk);
    result_in <= '{1'b1, d};
    @(posedge clk);
    result_in <= '{1'b0, ~d};
    @(posedge clk);
    check({31'h0, count_irq}, {31'h0, ci});
    check({31'h0, cmp_irq}, {31'h0, mi});
  endtask : res
  task automatic reconf;
    @(posedge clk);
    reconfig_wr <= 1'b1;
    @(posedge clk);
    reconfig_wr <= 1'b0;
  endtask : reconf
  initial begin
    {adc_config, twos_comp, acc_subtract, reconfig_wr} = '0;
    result_in = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    bus(0, CARP_ADDR_COUNT_LIMIT, 0, {16'h0, CARP_RST_COUNT_LIMIT});
    bus(0, CARP_ADDR_THRESHOLD, 0, 32'h0);
    bus(0, CARP_ADDR_ACCUM, 0, CARP_RST_ACCUM);
    bus(1, CARP_ADDR_COUNT_VALUE, 32'h5, 0);
    bus(0, CARP_ADDR_COUNT_VALUE, 0, 32'h0);
    bus(0, 32'hffff0554, 0, 32'h0);
    $display("test 1 done");
    bus(1, CARP_ADDR_COUNT_LIMIT, 32'h3, 0);
    adc_config <= 8'h01;
    for (int i = 1; i <= 7; i++) res(16'h10, i % 3 == 0, 1'b0);
    bus(0, CARP_ADDR_COUNT_VALUE, 0, 32'h1);
    adc_config <= 8'h00;
    res(16'h10, 1'b0, 1'b0);
    bus(0, CARP_ADDR_COUNT_VALUE, 0, 32'h1);
    reconf();
    bus(0, CARP_ADDR_COUNT_VALUE, 0, 32'h0);
    bus(1, CARP_ADDR_COUNT_LIMIT, 32'h1, 0);
    adc_config <= 8'h01;
    res(16'h10, 1'b1, 1'b0);
    res(16'h10, 1'b1, 1'b0);
    bus(0, CARP_ADDR_COUNT_VALUE, 0, 32'h0);
    $display("test 2 done");
    bus(1, CARP_ADDR_THRESHOLD, 32'h8000, 0);
    adc_config <= 8'h08;
    res(16'h8001, 1'b0, 1'b1);
    res(16'h8000, 1'b0, 1'b0);
    twos_comp <= 1'b1;
    bus(1, CARP_ADDR_THRESHOLD, 32'h8005, 0);
    res(16'hfffa, 1'b0, 1'b1);
    res(16'hfffb, 1'b0, 1'b0);
    res(16'h8000, 1'b0, 1'b1);
    adc_config <= 8'h00;
    res(16'hfffa, 1'b0, 1'b0);
    $display("test 3 done");
    adc_config <= 8'h20;
    res(16'h0100, 1'b0, 1'b0);
    res(16'hffff, 1'b0, 1'b0);
    bus(0, CARP_ADDR_ACCUM, 0, 32'h000000ff);
    acc_subtract <= 1'b1;
    res(16'h0001, 1'b0, 1'b0);
    {acc_subtract, twos_comp} <= 2'b00;
    res(16'hffff, 1'b0, 1'b0);
    bus(0, CARP_ADDR_ACCUM, 0, 32'h000100fd);
    reconf();
    bus(0, CARP_ADDR_ACCUM, 0, 32'h0);
    res(16'h0002, 1'b0, 1'b0);
    bus(0, CARP_ADDR_ACCUM, 0, 32'h2);
    adc_config <= 8'h00;
    bus(0, CARP_ADDR_ACCUM, 0, 32'h0);
    $display("test 4 done");
    bus(1, CARP_ADDR_COUNT_LIMIT, 32'h2, 0);
    adc_config <= 8'h01;
    res(16'h10, 1'b0, 1'b0);
    bus(0, CARP_ADDR_COUNT_VALUE, 0, 32'h1);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    bus(0, CARP_ADDR_COUNT_LIMIT, 0, {16'h0, CARP_RST_COUNT_LIMIT});
    bus(0, CARP_ADDR_COUNT_VALUE, 0, {16'h0, CARP_RST_COUNT_VALUE});
    bus(0, CARP_ADDR_THRESHOLD, 0, {16'h0, CARP_RST_THRESHOLD});
    $display("test 5 done");
    complete_run();
  end
endmodule : carp_bench
`default_nettype wire

// ### dv/carp_core.sv
// Purpose: processor side of the register bus
// Assumes: one-cycle strobes, answer within four cycles
// Notes:   released address and data lines carry the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module carp_core (
  // bus
  input  wire logic                   clk,
  output var carp_pkg::carp_bus_req_t bus_req,
  input  wire logic                   bus_ack,
  input  wire logic                   bus_hit,
  input  wire logic [31:0]            bus_rdata
);
  import carp_pkg::*;
  initial bus_req = '0;
  // accesses issued only after the clock edge has settled
  task automatic access(input logic w, input logic [31:0] a, d,
                        output logic [31:0] q, output logic h, output logic ok);
    ok = 1'b0;
    q = 32'h0;
    h = 1'b0;
    @(posedge clk);
    bus_req <= '{w, !w, a, d};
    @(posedge clk);
    bus_req <= '{1'b0, 1'b0, ~a, ~d};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      ok = (bus_ack === 1'b1);
      q = bus_rdata;
      h = bus_hit;
    end
  endtask : access
endmodule : carp_core
`default_nettype wire

// ### dv/carp_props.sv
// Purpose: port checks of carp_top
// Assumes: limit and threshold mirrored from bus writes
// Notes:   count and accumulator are judged by the bench
`timescale 1ns/100ps
`default_nettype none
module carp_props (
  // clock
  input wire logic                    clk,
  input wire logic                    resetn,
  // bus
  input wire carp_pkg::carp_bus_req_t bus_req,
  input wire logic                    bus_ack,
  input wire logic                    bus_hit,
  input wire logic [31:0]             bus_rdata,
  // adc side
  input wire logic [7:0]              adc_config,
  input wire logic                    twos_comp,
  input wire logic                    reconfig_wr,
  input wire carp_pkg::carp_result_t  result_in,
  input wire logic                    count_irq,
  input wire logic                    cmp_irq
);
  import carp_pkg::*;
  logic [15:0] th_reg, th_next, lim_reg, lim_next, mag, thr;
  logic        hit_addr;
  always_comb begin
    th_next  = resetn ? th_reg : CARP_RST_THRESHOLD;
    lim_next = resetn ? lim_reg : CARP_RST_COUNT_LIMIT;
    if (resetn && bus_req.wr && bus_req.addr == CARP_ADDR_THRESHOLD) th_next = bus_req.wdata[15:0];
    if (resetn && bus_req.wr && bus_req.addr == CARP_ADDR_COUNT_LIMIT) lim_next = bus_req.wdata[15:0];
    mag = result_in.data;
    thr = th_reg;
    if (twos_comp) begin
      thr[15] = 1'b0;
      if (mag[15]) mag = (mag == 16'h8000) ? 16'h7fff : -mag;
    end
    hit_addr = bus_req.addr inside {CARP_ADDR_COUNT_LIMIT, CARP_ADDR_COUNT_VALUE,
                                    CARP_ADDR_THRESHOLD, CARP_ADDR_ACCUM};
  end
  always_ff @(posedge clk) begin
    th_reg  <= th_next;
    lim_reg <= lim_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****
  // checks
  // ****
  ack_follows_req_a: assert property (bus_ack == $past(bus_req.rd || bus_req.wr))
    else $error("ack late");
  hit_decode_a: assert property (bus_ack |-> bus_hit == $past(hit_addr))
    else $error("bad hit");
  hit_needs_ack_a: assert property (bus_hit |-> bus_ack)
    else $error("hit without ack");
  write_data_zero_a: assert property (bus_ack && !$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("write data");
  short_reg_upper_a: assert property ($past(bus_req.rd && bus_req.addr != CARP_ADDR_ACCUM)
    |-> bus_rdata[31:16] == 16'h0)
    else $error("upper bits");
  cmp_irq_exact_a: assert property (cmp_irq == $past(result_in.valid && adc_config[3] && mag > thr))
    else $error("compare irq");
  count_irq_cause_a: assert property (count_irq |-> $past(result_in.valid && adc_config[0]))
    else $error("count irq");
  reconfig_quiet_a: assert property ($past(reconfig_wr) |-> !count_irq)
    else $error("irq on reconfig");
  limit_one_a: assert property ($past(lim_reg == 16'h1) |-> count_irq ==
    $past(result_in.valid && adc_config[0] && !reconfig_wr))
    else $error("limit one");
  cover property (count_irq);
  cover property (cmp_irq);
  cover property (bus_ack && !bus_hit);
endmodule : carp_props
bind carp_top carp_props chk (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_ack(bus_ack),
  .bus_hit(bus_hit), .bus_rdata(bus_rdata), .adc_config(adc_config), .twos_comp(twos_comp),
  .reconfig_wr(reconfig_wr), .result_in(result_in), .count_irq(count_irq), .cmp_irq(cmp_irq));
`default_nettype wire

// ### src/carp_mag.sv
// Purpose: magnitude of a current-channel result for threshold comparison
// Assumes: twos complement or unipolar coding chosen by the caller
// Notes:   most negative code saturates to 0x7fff

`timescale 1ns/100ps
`default_nettype none

module carp_mag (
  // result in
  input  wire logic [15:0] result,
  input  wire logic        twos_comp,
  // magnitude out
  output logic      [15:0] magnitude
);
  import carp_pkg::*;

  logic [15:0] neg;

  always_comb begin
    neg = 16'h0000 - result;
    if (!twos_comp) begin
      magnitude = result;
    end else if (!result[15]) begin
      magnitude = result;
    end else if (result == 16'h8000) begin
      magnitude = 16'h7fff;
    end else begin
      magnitude = neg;
    end
  end

endmodule : carp_mag

`default_nettype wire

// ### src/carp_pkg.sv
// Purpose: constants and types for the current-channel result post-processor
// Assumes: 32-bit memory-mapped register bus, byte addresses
// Notes:   control/config/mode registers live outside; their writes arrive as strobes

package carp_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [31:0] CARP_ADDR_COUNT_LIMIT = 32'hffff0548;
  localparam logic [31:0] CARP_ADDR_COUNT_VALUE = 32'hffff054c;
  localparam logic [31:0] CARP_ADDR_THRESHOLD   = 32'hffff0550;
  localparam logic [31:0] CARP_ADDR_ACCUM       = 32'hffff055c;

  localparam logic [15:0] CARP_RST_COUNT_LIMIT = 16'h0001;
  localparam logic [15:0] CARP_RST_COUNT_VALUE = 16'h0000;
  localparam logic [15:0] CARP_RST_THRESHOLD   = 16'h0000;
  localparam logic [31:0] CARP_RST_ACCUM       = 32'h00000000;

  // ********************************************************
  // adc_config field positions
  // ********************************************************
  localparam int CARP_CFG_COUNT_EN = 0;
  localparam int CARP_CFG_CMP_EN   = 3;
  localparam int CARP_CFG_ACC_EN   = 5;

  // ********************************************************
  // types
  // ********************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } carp_bus_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } carp_result_t;

  typedef enum logic [1:0] {
    CARP_ACC_IDLE = 2'b00,
    CARP_ACC_RUN  = 2'b01,
    CARP_ACC_CLR  = 2'b11
  } carp_acc_state_t;

endpackage : carp_pkg

// ### src/carp_top.sv
// Purpose: result counter, threshold comparator and accumulator of the current channel
// Assumes: one result strobe per finished conversion, synchronous to clk
// Notes:   reads answer in the cycle after the read strobe

`timescale 1ns/100ps
`default_nettype none

module carp_top (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // register bus
  input  wire carp_pkg::carp_bus_req_t bus_req,
  output logic                        bus_ack,
  output logic                        bus_hit,
  output logic [31:0]                 bus_rdata,
  // configuration from adc_config and adc_mode
  input  wire logic [7:0]             adc_config,
  input  wire logic                   twos_comp,
  input  wire logic                   acc_subtract,
  input  wire logic                   reconfig_wr,
  // results from filter path
  input  wire carp_pkg::carp_result_t result_in,
  // events to interrupt logic
  output logic                        count_irq,
  output logic                        cmp_irq
);
  import carp_pkg::*;

  // ********************************************************
  // address decode
  // ********************************************************
  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  // one select line per mapped register; index order is the read mux order
  localparam int CARP_NUM_REGS = 4;
  localparam int SEL_LIMIT     = 0;
  localparam int SEL_VALUE     = 1;
  localparam int SEL_THRESH    = 2;
  localparam int SEL_ACCUM     = 3;
  localparam logic [CARP_NUM_REGS-1:0][31:0] REG_ADDR = {
    CARP_ADDR_ACCUM,
    CARP_ADDR_THRESHOLD,
    CARP_ADDR_COUNT_VALUE,
    CARP_ADDR_COUNT_LIMIT
  };

  logic [CARP_NUM_REGS-1:0] reg_sel;
  logic                     bus_access;
  logic                     wr_limit;
  logic                     wr_thresh;
  logic                     hit;

  for (genvar g = 0; g < CARP_NUM_REGS; g++) begin : g_sel
    assign reg_sel[g] = addr_is(bus_req.addr, REG_ADDR[g]);
  end

  always_comb begin
    bus_access = bus_req.rd || bus_req.wr;
    wr_limit   = bus_req.wr && reg_sel[SEL_LIMIT];
    wr_thresh  = bus_req.wr && reg_sel[SEL_THRESH];
    // an idle bus may still show a mapped address; hit follows strobes only
    hit        = bus_access && (|reg_sel);
  end

  // ********************************************************
  // writable registers
  // ********************************************************
  // writes land at the edge that takes the strobe; ack rises at that same edge
  logic [15:0] limit_reg;
  logic [15:0] limit_next;
  logic [15:0] thresh_reg;
  logic [15:0] thresh_next;

  always_comb begin
    limit_next  = limit_reg;
    thresh_next = thresh_reg;
    if (wr_limit) begin
      limit_next = bus_req.wdata[15:0];
    end
    if (wr_thresh) begin
      thresh_next = bus_req.wdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      limit_reg  <= CARP_RST_COUNT_LIMIT;
      thresh_reg <= CARP_RST_THRESHOLD;
    end else begin
      limit_reg  <= limit_next;
      thresh_reg <= thresh_next;
    end
  end

  // ********************************************************
  // configuration decode
  // ********************************************************
  // enables are levels of the outer config register, used as they stand
  logic cfg_count_en;
  logic cfg_cmp_en;
  logic cfg_acc_en;

  always_comb begin
    cfg_count_en = adc_config[CARP_CFG_COUNT_EN];
    cfg_cmp_en   = adc_config[CARP_CFG_CMP_EN];
    cfg_acc_en   = adc_config[CARP_CFG_ACC_EN];
  end

  // ********************************************************
  // result counter
  // ********************************************************
  // limit 0 never matches until the count wraps past 16'hffff, and a limit
  // lowered below the running count behaves the same way
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        count_irq_reg;
  logic        count_irq_next;
  logic [15:0] count_inc;

  always_comb begin
    count_inc      = count_reg + 16'h0001;
    count_next     = count_reg;
    count_irq_next = 1'b0;
    // reconfiguration wins over a result in the same cycle
    if (reconfig_wr) begin
      count_next = 16'h0000;
    end else if (result_in.valid && cfg_count_en) begin
      // wrap fires the interrupt in the same step the count reaches the limit
      if (count_inc == limit_reg) begin
        count_next     = 16'h0000;
        count_irq_next = 1'b1;
      end else begin
        count_next = count_inc;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_reg     <= CARP_RST_COUNT_VALUE;
      count_irq_reg <= 1'b0;
    end else begin
      count_reg     <= count_next;
      count_irq_reg <= count_irq_next;
    end
  end

  // ********************************************************
  // threshold comparator
  // ********************************************************
  logic [15:0] magnitude;
  logic [15:0] thresh_eff;
  logic        cmp_irq_reg;
  logic        cmp_irq_next;

  carp_mag u_mag (
    .result    (result_in.data),
    .twos_comp (twos_comp),
    .magnitude (magnitude)
  );

  always_comb begin
    thresh_eff   = twos_comp ? {1'b0, thresh_reg[14:0]} : thresh_reg;
    // strict greater-than: a result equal to the threshold stays quiet
    cmp_irq_next = result_in.valid && cfg_cmp_en
                   && (magnitude > thresh_eff);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmp_irq_reg <= 1'b0;
    end else begin
      cmp_irq_reg <= cmp_irq_next;
    end
  end

  // ********************************************************
  // accumulator
  // ********************************************************
  // wraps silently at 32 bits; software must read it before it rolls over
  carp_acc_state_t acc_state_reg;
  carp_acc_state_t acc_state_next;
  logic [31:0]     acc_reg;
  logic [31:0]     acc_next;
  logic [31:0]     sample_ext;

  always_comb begin
    // unipolar results are zero-extended so large codes do not turn negative
    sample_ext     = twos_comp ? {{16{result_in.data[15]}}, result_in.data}
                               : {16'h0000, result_in.data};
    acc_next       = acc_reg;
    acc_state_next = acc_state_reg;
    case (acc_state_reg)
      CARP_ACC_IDLE: begin
        acc_next = 32'h00000000;
        // a result in the enabling cycle is dropped: idle needs an edge to leave
        if (cfg_acc_en) begin
          acc_state_next = CARP_ACC_RUN;
        end
      end
      CARP_ACC_RUN: begin
        // disable outranks reconfiguration, which outranks a result
        if (!cfg_acc_en) begin
          acc_next       = 32'h00000000;
          acc_state_next = CARP_ACC_IDLE;
        end else if (reconfig_wr) begin
          acc_next = 32'h00000000;
        end else if (result_in.valid) begin
          acc_next = acc_subtract ? acc_reg - sample_ext
                                  : acc_reg + sample_ext;
        end
      end
      default: begin
        acc_next       = 32'h00000000;
        acc_state_next = CARP_ACC_IDLE;
      end
    endcase
    if (acc_state_reg == CARP_ACC_IDLE && reconfig_wr) begin
      acc_next = 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_state_reg <= CARP_ACC_IDLE;
      acc_reg       <= CARP_RST_ACCUM;
    end else begin
      acc_state_reg <= acc_state_next;
      acc_reg       <= acc_next;
    end
  end

  // ********************************************************
  // read path
  // ********************************************************
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;
  logic        hit_reg;
  logic        hit_next;

  always_comb begin
    // writes and unmapped reads return zero; every strobe is acknowledged
    rdata_next = 32'h00000000;
    ack_next   = bus_access;
    hit_next   = hit;
    if (bus_req.rd) begin
      if (reg_sel[SEL_LIMIT]) begin
        rdata_next = {16'h0000, limit_reg};
      end else if (reg_sel[SEL_VALUE]) begin
        rdata_next = {16'h0000, count_reg};
      end else if (reg_sel[SEL_THRESH]) begin
        rdata_next = {16'h0000, thresh_reg};
      end else if (reg_sel[SEL_ACCUM]) begin
        rdata_next = acc_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_reg <= 32'h00000000;
      ack_reg   <= 1'b0;
      hit_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      hit_reg   <= hit_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign bus_ack   = ack_reg;
  assign bus_hit   = hit_reg;
  // irqs are single-cycle pulses; the interrupt controller latches them
  assign count_irq = count_irq_reg;
  assign cmp_irq   = cmp_irq_reg;

endmodule : carp_top

`default_nettype wire
